// ---- verilog/adcrs_pkg.sv ----
// Purpose: Shared constants for the converter serial readout link
// Assumes: Core clock of 20 MHz on both ends
// Notes: Timing counts derive from times in nanoseconds
package adcrs_pkg;
  // ----------------------------------------
  // Addressing
  // ----------------------------------------
  localparam logic [3:0] DEV_CODE = 4'hC; // Arbitrary device code value
  localparam logic [2:0] ADDR_SEL_DEFAULT = 3'h5;
  localparam int RESULT_W = 12;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int ACQ_TIME_NS = 1120;
  localparam int CONV_TIME_NS = 8960;
  localparam int ACQ_CYC = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_CYC = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCL_HALF_CYC = 4; // Master divider: quarter of the bus clock period in core clocks
endpackage : adcrs_pkg

// ---- verilog/adcrs_if.sv ----
// Purpose: Two-wire link between master and converter
// Assumes: Open-drain lines with pull-ups resolved here
// Notes: A line is low when any party enables its driver
`timescale 1ns/1ps
`default_nettype none
interface adcrs_if;
  logic scl_o_en;
  logic sda_m_en;
  logic sda_s_en;
  logic scl;
  logic sda;
  // Wired-AND of the open-drain drivers
  assign scl = !scl_o_en;
  assign sda = !(sda_m_en || sda_s_en);
  modport master (output scl_o_en, output sda_m_en, input scl, input sda);
  modport slave (output sda_s_en, input scl, input sda);
endinterface : adcrs_if
`default_nettype wire

// ---- verilog/adcrs_slave.sv ----
// Purpose: Converter end: address match, self-timed conversion, result readout
// Assumes: Bus lines sampled by the core clock through two flip-flops
// Notes: Result comes from a digital input standing in for the analog input
// Operation
// - First byte after START is address
// - Respond only on matching device code
// - Three select bits follow, default 101
// - Eighth bit one reads, zero writes
// - Write address acked, then line released
// - Conversion starts on direction bit falling edge; code starts it only when that bit is one (read), not on a poll
// - Acknowledge low during next clock pulse
// - Master releases data during address ack
// - First byte: four zeros, upper four bits
// - Master acks; lower eight bits follow
// - Master nacks last byte to finish
// - Ack after second byte restarts sampling; code restarts on the SCL fall ending the second byte, ack or nack
// - Master frames with START and STOP
// - Result saturates at 000h and FFFh
// - After poll, STOP or repeated START
// - Result sent MSB first, straight binary
// - Acquisition 1.12 us, conversion 8.96 us
// - Release line after master nack
`timescale 1ns/1ps
`default_nettype none
module adcrs_slave #(
  parameter logic [2:0] ADDR_SEL = adcrs_pkg::ADDR_SEL_DEFAULT
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic [11:0] i_analog_input,
  output logic o_busy,
  output logic [11:0] o_result,
  adcrs_if.slave bus
);
  typedef enum {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_TX, ST_MACK, ST_WAIT} adcrs_st_t;
  typedef enum {CV_IDLE, CV_ACQ, CV_CONV} adcrs_cv_t;
  // ----------------------------------------
  // Line synchronisers and edges
  // ----------------------------------------
  logic [1:0] scl_s_q;
  logic [1:0] sda_s_q;
  logic scl_d1_q;
  logic sda_d1_q;
  // Two flops per line, then one delay for edge finding
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[0], bus.scl};
      sda_s_q <= {sda_s_q[0], bus.sda};
      scl_d1_q <= scl_s_q[1];
      sda_d1_q <= sda_s_q[1];
    end
  end
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  // Edge and bus condition decode
  assign scl_rise = scl_s_q[1] && !scl_d1_q;
  assign scl_fall = !scl_s_q[1] && scl_d1_q;
  assign start_det = scl_s_q[1] && scl_d1_q && !sda_s_q[1] && sda_d1_q;
  assign stop_det = scl_s_q[1] && scl_d1_q && sda_s_q[1] && !sda_d1_q;
  // ----------------------------------------
  // Protocol state
  // ----------------------------------------
  adcrs_st_t st_q;
  logic [7:0] sh_q;
  logic [3:0] bit_q;
  logic byte_hi_q;
  logic rd_q;
  logic sda_en_q;
  logic conv_go;
  logic [7:0] tx_byte;
  // Upper byte holds four zeros and result top nibble
  assign tx_byte = byte_hi_q ? {4'h0, o_result[11:8]} : o_result[7:0];
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_q <= ST_IDLE;
      sh_q <= 8'h00;
      bit_q <= 4'h0;
      byte_hi_q <= 1'b1;
      rd_q <= 1'b0;
      sda_en_q <= 1'b0;
      conv_go <= 1'b0;
    end else begin
      conv_go <= 1'b0;
      if (stop_det) begin
        st_q <= ST_IDLE;
        sda_en_q <= 1'b0;
      end else if (start_det) begin
        st_q <= ST_ADDR;
        bit_q <= 4'h0;
        sda_en_q <= 1'b0;
      end else begin
        case (st_q)
          ST_ADDR: begin
            if (scl_rise) begin
              sh_q <= {sh_q[6:0], sda_s_q[1]};
              bit_q <= bit_q + 4'h1;
            end else if (scl_fall && bit_q == 4'h8) begin
              if (sh_q[7:4] == adcrs_pkg::DEV_CODE && sh_q[3:1] == ADDR_SEL) begin
                st_q <= ST_ADDR_ACK;
                byte_hi_q <= 1'b1;
                sda_en_q <= 1'b1;
                rd_q <= sh_q[0];
                conv_go <= sh_q[0];
              end else begin
                st_q <= ST_WAIT;
              end
            end
          end
          ST_ADDR_ACK: begin
            if (scl_fall) begin
              bit_q <= 4'h0;
              byte_hi_q <= 1'b1;
              if (rd_q) begin
                st_q <= ST_TX;
                sda_en_q <= !tx_byte[7];
                sh_q <= {tx_byte[6:0], 1'b0};
              end else begin
                st_q <= ST_WAIT;
                sda_en_q <= 1'b0;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              bit_q <= bit_q + 4'h1;
              if (bit_q == 4'h7) begin
                st_q <= ST_MACK;
                sda_en_q <= 1'b0;
                if (!byte_hi_q) conv_go <= 1'b1;
              end else begin
                sda_en_q <= !sh_q[7];
                sh_q <= {sh_q[6:0], 1'b0};
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              // Master ack low continues, high ends the read
              if (sda_s_q[1]) st_q <= ST_WAIT;
            end else if (scl_fall) begin
              st_q <= ST_TX;
              bit_q <= 4'h0;
              byte_hi_q <= !byte_hi_q;
              sda_en_q <= byte_hi_q ? !o_result[7] : 1'b1;
              sh_q <= byte_hi_q ? {o_result[6:0], 1'b0} : {3'h0, o_result[11:8], 1'b0};
            end
          end
          default: begin
            sda_en_q <= 1'b0;
          end
        endcase
      end
    end
  end
  assign bus.sda_s_en = sda_en_q;
  // ----------------------------------------
  // Self-timed conversion
  // ----------------------------------------
  adcrs_cv_t cv_q;
  logic [15:0] cnt_q;
  logic [11:0] held_q;
  // Acquire, hold and convert on core clock, independent of the bus clock
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cv_q <= CV_IDLE;
      cnt_q <= 16'h0000;
      held_q <= 12'h000;
      o_result <= 12'h000;
    end else begin
      case (cv_q)
        CV_IDLE: begin
          if (conv_go) begin
            cv_q <= CV_ACQ;
            cnt_q <= 16'(adcrs_pkg::ACQ_CYC - 1);
          end
        end
        CV_ACQ: begin
          if (cnt_q == 16'h0000) begin
            cv_q <= CV_CONV;
            held_q <= i_analog_input;
            cnt_q <= 16'(adcrs_pkg::CONV_CYC - 1);
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
        default: begin
          if (cnt_q == 16'h0000) begin
            cv_q <= CV_IDLE;
            o_result <= held_q;
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
      endcase
    end
  end
  assign o_busy = (cv_q != CV_IDLE);
endmodule : adcrs_slave
`default_nettype wire

// ---- verilog/adcrs_master.sv ----
// Purpose: Bus master end: address, poll and read conversions
// Assumes: Bus clock made here by dividing the core clock
// Notes: One request per transaction; count sets conversions to read
`timescale 1ns/1ps
`default_nettype none
module adcrs_master #(
  parameter int HALF_CYC = adcrs_pkg::SCL_HALF_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_req,
  input wire logic [6:0] i_addr,
  input wire logic i_read,
  input wire logic [7:0] i_count,
  output logic o_busy,
  output logic o_ack_seen,
  output logic [11:0] o_data,
  output logic o_data_valid,
  adcrs_if.master bus
);
  typedef enum {MS_IDLE, MS_START, MS_BIT, MS_STOP} adcrs_ms_t;
  adcrs_ms_t st_q;
  logic [7:0] div_q;
  logic [1:0] ph_q;
  logic [4:0] bit_q;
  logic [8:0] tx_q;
  logic [15:0] rx_q;
  logic [7:0] left_q;
  logic rd_q;
  logic scl_en_q;
  logic sda_en_q;
  logic [1:0] sda_s_q;
  logic tick;
  // Synchronise the data line before it is read
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) sda_s_q <= 2'h3;
    else sda_s_q <= {sda_s_q[0], bus.sda};
  end
  assign tick = (div_q == 8'(HALF_CYC - 1));
  // Quarter-phase sequencer: 0 low set data, 1 rise, 2 high sample, 3 fall
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_q <= MS_IDLE;
      div_q <= 8'h00;
      ph_q <= 2'h0;
      bit_q <= 5'h00;
      tx_q <= 9'h000;
      rx_q <= 16'h0000;
      left_q <= 8'h00;
      rd_q <= 1'b0;
      scl_en_q <= 1'b0;
      sda_en_q <= 1'b0;
      o_ack_seen <= 1'b0;
      o_data <= 12'h000;
      o_data_valid <= 1'b0;
    end else begin
      o_data_valid <= 1'b0;
      div_q <= tick ? 8'h00 : div_q + 8'h01;
      case (st_q)
        MS_IDLE: begin
          div_q <= 8'h00;
          if (i_req) begin
            st_q <= MS_START;
            rd_q <= i_read;
            left_q <= i_count;
            tx_q <= {i_addr, i_read, 1'b1};
            bit_q <= 5'h00;
            o_ack_seen <= 1'b0;
            sda_en_q <= 1'b1;
          end
        end
        MS_START: begin
          if (tick) begin
            st_q <= MS_BIT;
            scl_en_q <= 1'b1;
            ph_q <= 2'h0;
          end
        end
        MS_BIT: begin
          if (tick) begin
            ph_q <= ph_q + 2'h1;
            if (ph_q == 2'h0) sda_en_q <= !tx_q[8];
            if (ph_q == 2'h1) scl_en_q <= 1'b0;
            if (ph_q == 2'h2) begin
              rx_q <= {rx_q[14:0], sda_s_q[1]};
              if (bit_q == 5'h08) o_ack_seen <= !sda_s_q[1];
            end
            if (ph_q == 2'h3) begin
              scl_en_q <= 1'b1;
              bit_q <= bit_q + 5'h01;
              tx_q <= {tx_q[7:0], 1'b1};
              if (bit_q == 5'h08) begin
                if (!rd_q || !o_ack_seen || left_q == 8'h00) st_q <= MS_STOP;
                else tx_q <= {8'hFF, 1'b0};
              end
              if (bit_q == 5'h11 || bit_q == 5'h1A) begin
                tx_q <= {8'hFF, 1'b0};
              end
              if (bit_q == 5'h1A) begin
                // Skip the ack sampled between the two bytes
                o_data <= {rx_q[13:10], rx_q[8:1]};
                o_data_valid <= 1'b1;
                left_q <= left_q - 8'h01;
                bit_q <= 5'h09;
                if (left_q == 8'h01) st_q <= MS_STOP;
              end
              if (bit_q == 5'h19 && left_q == 8'h01) tx_q <= 9'h1FF;
              if (bit_q == 5'h19 && left_q != 8'h01) tx_q <= {1'b0, 8'hFF};
            end
          end
        end
        default: begin
          if (tick) begin
            ph_q <= ph_q + 2'h1;
            if (ph_q == 2'h0) sda_en_q <= 1'b1;
            if (ph_q == 2'h1) scl_en_q <= 1'b0;
            if (ph_q == 2'h3) begin
              sda_en_q <= 1'b0;
              st_q <= MS_IDLE;
            end
          end
        end
      endcase
    end
  end
  assign bus.scl_o_en = scl_en_q;
  assign bus.sda_m_en = sda_en_q;
  assign o_busy = (st_q != MS_IDLE);
endmodule : adcrs_master
`default_nettype wire

// ---- sim/adcrs_monitor.sv ----
// Purpose: Wire checks on the shared two-wire link
// Assumes: Converter at default select bits
// Notes: Counts SCL rises since each START
`timescale 1ns/1ps
`default_nettype none
module adcrs_monitor (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic scl_o_en,
  input wire logic sda_m_en,
  input wire logic sda_s_en,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q, sda_q, hit_q, rd_q, more_q;
  logic [7:0] cnt_q, sh_q;
  wire logic rise = scl && !scl_q;
  wire logic start = scl && scl_q && sda_q && !sda;
  wire logic hit = sh_q[7:1] == {adcrs_pkg::DEV_CODE, adcrs_pkg::ADDR_SEL_DEFAULT};
  // Line history for edge finding
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end
  // Rise count and address shifter
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_q <= 8'h00;
      sh_q <= 8'h00;
    end else if (start) begin
      cnt_q <= 8'h00;
    end else if (rise) begin
      cnt_q <= cnt_q + 8'(cnt_q != 8'hff);
      sh_q <= {sh_q[6:0], sda};
    end
  end
  // Match, direction and continue flags
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hit_q <= 1'b0;
      rd_q <= 1'b0;
      more_q <= 1'b0;
    end else if (start || (rise && cnt_q == 8'h08)) begin
      hit_q <= !start && hit;
      rd_q <= !start && hit && sh_q[0];
      more_q <= 1'b0;
    end else if (rise && cnt_q == 8'h1a) begin
      more_q <= rd_q && !sda;
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  sequence s_low3;
    scl_o_en [*3];
  endsequence
  sequence s_gone;
    ##5 !sda_s_en;
  endsequence
  chk_addr_quiet: assert property (rise && cnt_q < 8'h08 |-> !sda_s_en)
    else $error("sda driven in address");
  chk_addr_ack: assert property (rise && cnt_q == 8'h08 && hit |-> sda_s_en && !sda_m_en)
    else $error("address ack wrong");
  chk_no_match: assert property (rise && cnt_q >= 8'h08 && !hit_q && !(cnt_q == 8'h08 && hit)
    |-> !sda_s_en)
    else $error("ack on foreign address");
  chk_lead_zeros: assert property (rise && rd_q && cnt_q inside {[8'h09:8'h0c]} |-> sda_s_en)
    else $error("lead bit not zero");
  chk_next_zeros: assert property (rise && more_q && cnt_q inside {[8'h1b:8'h1e]} |-> sda_s_en)
    else $error("next result missing");
  chk_ack_slot: assert property (rise && rd_q && (cnt_q == 8'h11 || cnt_q == 8'h1a)
    |-> !sda_s_en && (cnt_q == 8'h1a || sda_m_en))
    else $error("ack slot wrong");
  chk_nack_free: assert property (rise && rd_q && cnt_q == 8'h1a && sda
    |-> ##1 !sda_s_en [*8])
    else $error("line held after nack");
  chk_poll_free: assert property ($fell(scl) && hit_q && !rd_q && cnt_q == 8'h09 |-> s_gone)
    else $error("line held after poll");
  chk_scl_low: assert property ($rose(scl_o_en) |=> s_low3)
    else $error("scl low too short");
endmodule : adcrs_monitor
`default_nettype wire

// ---- sim/adcrs_tb.sv ----
// Purpose: Bench for master and converter ends on one link
// Assumes: Input held steady while a value is read back
// Notes: Each value is primed by one read, then read twice
`timescale 1ns/1ps
`default_nettype none
module adc_result_serial_readout_tb;
  localparam logic [6:0] ADDR = {adcrs_pkg::DEV_CODE, adcrs_pkg::ADDR_SEL_DEFAULT};
  logic i_core_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic req = 1'b0;
  logic rd = 1'b0;
  logic [6:0] addr = 7'h00;
  logic [7:0] count = 8'h00;
  logic [11:0] analog_input = 12'h000;
  logic m_busy, ack_seen, dv, s_busy;
  logic [11:0] data, result;
  logic [11:0] vals [4] = '{12'h000, 12'hfff, 12'ha5c, 12'h801};
  logic [11:0] got [$];
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;
  adcrs_if bus ();
  adcrs_master u_adcrs_master (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_req(req),
    .i_addr(addr), .i_read(rd), .i_count(count), .o_busy(m_busy), .o_ack_seen(ack_seen),
    .o_data(data), .o_data_valid(dv), .bus(bus));
  adcrs_slave u_adcrs_slave (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
    .i_analog_input(analog_input), .o_busy(s_busy), .o_result(result), .bus(bus));
  adcrs_monitor u_adcrs_monitor (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
    .scl_o_en(bus.scl_o_en), .sda_m_en(bus.sda_m_en), .sda_s_en(bus.sda_s_en),
    .scl(bus.scl), .sda(bus.sda));
  // Clock
  always #25 i_core_clk = ~i_core_clk;
  task automatic end_of_test();
    if (bad_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test
  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // One transaction, then wait until both ends are idle
  task automatic xfer(input logic [6:0] a, input logic r, input logic [7:0] n);
    int t;
    t = 0;
    got.delete();
    @(posedge i_core_clk);
    req <= 1'b1;
    addr <= a;
    rd <= r;
    count <= n;
    do begin
      @(posedge i_core_clk);
      t++;
    end while (m_busy !== 1'b1 && t < 50);
    req <= 1'b0;
    while ((m_busy !== 1'b0 || s_busy !== 1'b0) && t < 3000) begin
      @(posedge i_core_clk);
      t++;
    end
    // A transfer that never finishes counts as a mismatch
    if (t >= 3000) bad_count++;
    repeat (4) @(posedge i_core_clk);
  endtask : xfer
  // Result capture and hang guard
  always @(posedge i_core_clk) begin
    cyc++;
    if (dv === 1'b1) got.push_back(data);
    if (cyc == 40000) begin
      bad_count++;
      end_of_test();
    end
  end
  // Poll, foreign addresses, then values read back
  initial begin
    repeat (5) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    xfer(ADDR, 1'b0, 8'h00);
    check("poll ack", 12'(ack_seen), 12'h001);
    check("poll data", 12'(got.size()), 12'h000);
    xfer({4'h6, adcrs_pkg::ADDR_SEL_DEFAULT}, 1'b1, 8'h01);
    check("code ack", 12'(ack_seen), 12'h000);
    xfer({adcrs_pkg::DEV_CODE, 3'h4}, 1'b1, 8'h01);
    check("select ack", 12'(ack_seen), 12'h000);
    foreach (vals[i]) begin
      analog_input <= vals[i];
      xfer(ADDR, 1'b1, 8'h01);
      check("result", result, vals[i]);
      xfer(ADDR, 1'b1, 8'h02);
      check("read ack", 12'(ack_seen), 12'h001);
      check("count", 12'(got.size()), 12'h002);
      check("first", got[0], vals[i]);
      check("second", got[1], vals[i]);
    end
    end_of_test();
  end
endmodule : adc_result_serial_readout_tb
`default_nettype wire
